// ==== hw/vocs_consts.vh ====
// Offsets, field positions, reset values and timing for the overlay block.
`ifndef VOCS_CONSTS_VH
`define VOCS_CONSTS_VH
`define VOCS_OFS_HBOUNDS     8'h08
`define VOCS_OFS_VBOUNDS     8'h0c
`define VOCS_OFS_SCALE       8'h10
`define VOCS_OFS_KEY         8'h14
`define VOCS_OFS_MASK        8'h18
`define VOCS_OFS_GPTR        8'h1c
`define VOCS_OFS_GPORT       8'h20
`define VOCS_OFS_PLL         8'h24
`define VOCS_OFS_SIG         8'h28
`define VOCS_POS_MASK        32'h07ff_07ff
`define VOCS_SCALE_MASK      32'h3fff_3fff
`define VOCS_C24_MASK        32'h00ff_ffff
`define VOCS_PTR_MASK        32'h0000_00ff
`define VOCS_PLL_MASK        32'hdfff_fd07
`define VOCS_PLL_RST         32'h0000_0000
`define VOCS_SIG_WMASK       32'h0000_00ef
`define VOCS_SIG_RST         32'h0000_0100
`define VOCS_SIG_SEED        24'h00_0001
`define VOCS_CRC_POLY        24'h80_0063
`define VOCS_PLL_FBRST       31
`define VOCS_PLL_HALF        30
`define VOCS_PLL_PD_HI       28
`define VOCS_PLL_PD_LO       24
`define VOCS_PLL_N_HI        22
`define VOCS_PLL_N_LO        12
`define VOCS_PLL_ON          11
`define VOCS_PLL_TVSEL       10
`define VOCS_PLL_BYP         8
`define VOCS_PD_ONE          5'h0_f
`define VOCS_SIG_OVR         7
`define VOCS_SIG_INVCLK      6
`define VOCS_SIG_INVEVEN     5
`define VOCS_SIG_SRC         3
`define VOCS_SIG_FREE        2
`define VOCS_SIG_HDLY        1
`define VOCS_SIG_EN          0
`define VOCS_HSYNC_DLY       2
`define VOCS_VCO_MIN_MHZ     140
`define VOCS_VCO_MAX_MHZ     300
`endif

// ==== hw/vocs_gamma_ram.v ====
// Gamma RAM: 256 words of 24 bits held in flip-flops.
`timescale 1ns/1ps
module vocs_gamma_ram (
  input  wire        clk,
  input  wire        ce,
  input  wire        we,
  input  wire [7:0]  addr,
  input  wire [23:0] wdata,
  input  wire [7:0]  raddr,
  output wire [23:0] rdata
);
  reg [23:0] mem [0:255];

  // No reset: palette contents are undefined until software loads them.
  always @(posedge clk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule // vocs_gamma_ram

// ==== hw/vocs_sig_crc.v ====
// Signature accumulator: 24-bit CRC over one pixel per enabled clock.
`timescale 1ns/1ps
`include "vocs_consts.vh"
module vocs_sig_crc (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        clear,
  input  wire        step,
  input  wire [23:0] pix,
  output reg  [23:0] sig_r
);
  reg  [23:0] sig_nxt;
  integer     i;

  always @* begin
    sig_nxt = sig_r;
    for (i = 0; i < 24; i = i + 1) begin
      if (sig_nxt[23] ^ pix[i]) begin
        sig_nxt = {sig_nxt[22:0], 1'b0} ^ `VOCS_CRC_POLY;
      end else begin
        sig_nxt = {sig_nxt[22:0], 1'b0};
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sig_r <= `VOCS_SIG_SEED;
    end else if (ce) begin
      if (clear) begin
        sig_r <= `VOCS_SIG_SEED;
      end else if (step) begin
        sig_r <= sig_nxt;
      end
    end
  end
endmodule // vocs_sig_crc

// ==== hw/vocs_top.v ====
// Overlay, gamma, pixel clock setup and signature register bank.
// Functional notes
// - Overlay X/Y start/end are 11-bit fields at bits 10:0 and 26:16.
// - Scale factors are 14-bit fields, 8192*(src-1)/(dst-1), software set.
// - Colour key is compared with the selected graphics or video stream.
// - Colour mask picks which stream bits join the key compare.
// - Writing palette address loads the gamma RAM address counter.
// - Palette data port writes or reads gamma RAM at the counter.
// - Feedback reset bit holds postscaler and feedback divider in reset.
// - Half-clock zero with odd post divisor uses VCO falling edge.
// - Five-bit post code maps to divisor 1..31, 11111 reserved; 01111 is one.
// - Eleven-bit feedback count field sets the VCO feedback divisor.
// - PLL enable bit gates the PLL, but post divisor one forces on.
// - Dot clock select picks PLL clock at zero, TV clock at one.
// - Bypass bit routes the reference input around the PLL.
// - Three-bit input divide code gives divisor code plus two.
// - Pixel clock = ref*FB/(post*input); VCO between 140 and 300 MHz.
// - Signature register upper 24 bits read signature; reset 00000100h.
// - Sync override drives CRT syncs onto the panel sync outputs.
// - Separate bits invert panel clock and even-pixel panel clock.
// - Signature source: RGB, or panel data padded with two low zeros.
// - Free run keeps capture going; clearing it stops at frame end.
// - Delay bit adds two clocks to panel horizontal sync under override.
// - Signature enable low seeds 000001h; high accumulates from next vsync.
`timescale 1ns/1ps
`include "vocs_consts.vh"
module vocs_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  input  wire [23:0] gfx_pixel,
  input  wire [23:0] vid_pixel,
  input  wire        key_use_video,
  output wire        key_match,
  input  wire [17:0] panel_pixel,
  input  wire [23:0] rgb_pixel,
  input  wire        crt_vsync,
  input  wire        crt_hsync,
  input  wire        panel_vsync_in,
  input  wire        panel_hsync_in,
  input  wire        panel_clk_in,
  input  wire        panel_even_clk_in,
  output reg         panel_vertical_sync_output,
  output reg         panel_horizontal_sync_output,
  output reg         panel_clock_output,
  output reg         panel_even_pixel_clock,
  output reg  [10:0] ovl_x_start,
  output reg  [10:0] ovl_x_end,
  output reg  [10:0] ovl_y_start,
  output reg  [10:0] ovl_y_end,
  output reg  [13:0] ovl_x_scale,
  output reg  [13:0] ovl_y_scale,
  input  wire [7:0]  gamma_lookup_idx,
  output reg  [23:0] gamma_lookup_data,
  output reg         pll_fb_reset,
  output reg         pll_half_clock_use,
  output reg  [4:0]  post_divisor,
  output reg  [10:0] pll_feedback_count,
  output reg         pll_enable,
  output reg         dot_clock_tv_select,
  output reg         pll_bypass,
  output reg  [3:0]  input_divisor
);
  reg  [31:0] hb_r;
  reg  [31:0] vb_r;
  reg  [31:0] sc_r;
  reg  [31:0] key_r;
  reg  [31:0] msk_r;
  reg  [7:0]  gptr_r;
  reg  [31:0] pll_r;
  reg  [7:0]  sig_ctl_r;
  reg         cap_r;
  reg         vs_d_r;
  reg  [1:0]  hs_dly_r;
  reg  [23:0] key_gfx_r;
  reg  [23:0] key_vid_r;
  reg         use_vid_r;
  reg         sig_done_r;

  wire [23:0] sig_val;
  wire [23:0] gram_rdata;
  wire [23:0] gram_lkdata;
  wire [4:0]  pd_code;
  wire        gram_we;
  wire        vs_rise;
  wire [23:0] sig_pix;
  wire [23:0] key_src;
  wire [4:0]  pd_val;
  wire [31:0] sig_wr_val;

  // Synchronisers for pins that come from outside the clock's domain.
  reg  [1:0]  vs_s_r;
  reg  [1:0]  hs_s_r;
  reg  [1:0]  pvs_s_r;
  reg  [1:0]  phs_s_r;
  reg  [1:0]  pck_s_r;
  reg  [1:0]  pev_s_r;

  function wr_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      wr_hit = reg_wr && (a == ofs);
    end
  endfunction

  // Post divisor decode; 0 marks the reserved code.
  function [4:0] pd_map;
    input [4:0] c;
    begin
      case (c)
        5'h00: pd_map = 5'd8;
        5'h01: pd_map = 5'd6;
        5'h02: pd_map = 5'd18;
        5'h03: pd_map = 5'd4;
        5'h04: pd_map = 5'd12;
        5'h05: pd_map = 5'd16;
        5'h06: pd_map = 5'd24;
        5'h07: pd_map = 5'd2;
        5'h08: pd_map = 5'd10;
        5'h09: pd_map = 5'd20;
        5'h0a: pd_map = 5'd14;
        5'h0b: pd_map = 5'd26;
        5'h0c: pd_map = 5'd22;
        5'h0d: pd_map = 5'd28;
        5'h0e: pd_map = 5'd30;
        5'h0f: pd_map = 5'd1;
        5'h10: pd_map = 5'd9;
        5'h11: pd_map = 5'd7;
        5'h12: pd_map = 5'd19;
        5'h13: pd_map = 5'd5;
        5'h14: pd_map = 5'd13;
        5'h15: pd_map = 5'd17;
        5'h16: pd_map = 5'd25;
        5'h17: pd_map = 5'd3;
        5'h18: pd_map = 5'd11;
        5'h19: pd_map = 5'd21;
        5'h1a: pd_map = 5'd15;
        5'h1b: pd_map = 5'd27;
        5'h1c: pd_map = 5'd23;
        5'h1d: pd_map = 5'd29;
        5'h1e: pd_map = 5'd31;
        default: pd_map = 5'd0;
      endcase
    end
  endfunction

  assign pd_code = pll_r[`VOCS_PLL_PD_HI:`VOCS_PLL_PD_LO];
  assign pd_val  = pd_map(pd_code);
  assign sig_wr_val = reg_wdata & `VOCS_SIG_WMASK;
  assign gram_we = wr_hit(reg_addr, `VOCS_OFS_GPORT);

  vocs_gamma_ram u_gram (
    .clk   (clk),
    .ce    (ce),
    .we    (gram_we),
    .addr  (gptr_r),
    .wdata (reg_wdata[23:0]),
    .raddr (gptr_r),
    .rdata (gram_rdata)
  );

  vocs_gamma_ram u_gram_lk (
    .clk   (clk),
    .ce    (ce),
    .we    (gram_we),
    .addr  (gptr_r),
    .wdata (reg_wdata[23:0]),
    .raddr (gamma_lookup_idx),
    .rdata (gram_lkdata)
  );

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vs_s_r  <= 2'b00;
      hs_s_r  <= 2'b00;
      pvs_s_r <= 2'b00;
      phs_s_r <= 2'b00;
      pck_s_r <= 2'b00;
      pev_s_r <= 2'b00;
    end else if (ce) begin
      vs_s_r  <= {vs_s_r[0], crt_vsync};
      hs_s_r  <= {hs_s_r[0], crt_hsync};
      pvs_s_r <= {pvs_s_r[0], panel_vsync_in};
      phs_s_r <= {phs_s_r[0], panel_hsync_in};
      pck_s_r <= {pck_s_r[0], panel_clk_in};
      pev_s_r <= {pev_s_r[0], panel_even_clk_in};
    end
  end

  // Register writes; reserved bits are masked so they always read zero.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hb_r      <= 32'h0000_0000;
      vb_r      <= 32'h0000_0000;
      sc_r      <= 32'h0000_0000;
      key_r     <= 32'h0000_0000;
      msk_r     <= 32'h0000_0000;
      gptr_r    <= 8'h00;
      pll_r     <= `VOCS_PLL_RST;
      sig_ctl_r <= 8'h00;
    end else if (ce) begin
      if (wr_hit(reg_addr, `VOCS_OFS_HBOUNDS))
        hb_r <= reg_wdata & `VOCS_POS_MASK;
      if (wr_hit(reg_addr, `VOCS_OFS_VBOUNDS))
        vb_r <= reg_wdata & `VOCS_POS_MASK;
      if (wr_hit(reg_addr, `VOCS_OFS_SCALE))
        sc_r <= reg_wdata & `VOCS_SCALE_MASK;
      if (wr_hit(reg_addr, `VOCS_OFS_KEY))
        key_r <= reg_wdata & `VOCS_C24_MASK;
      if (wr_hit(reg_addr, `VOCS_OFS_MASK))
        msk_r <= reg_wdata & `VOCS_C24_MASK;
      // Pointer load wins over the auto-increment after a data access.
      if (wr_hit(reg_addr, `VOCS_OFS_GPTR))
        gptr_r <= reg_wdata[7:0];
      else if ((reg_wr || reg_rd) && reg_addr == `VOCS_OFS_GPORT)
        gptr_r <= gptr_r + 8'h01;
      if (wr_hit(reg_addr, `VOCS_OFS_PLL))
        pll_r <= reg_wdata & `VOCS_PLL_MASK;
      if (wr_hit(reg_addr, `VOCS_OFS_SIG))
        sig_ctl_r <= sig_wr_val[7:0];
    end
  end

  // Read data is registered; unmapped offsets read as zero.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `VOCS_OFS_HBOUNDS: reg_rdata <= hb_r;
        `VOCS_OFS_VBOUNDS: reg_rdata <= vb_r;
        `VOCS_OFS_SCALE:   reg_rdata <= sc_r;
        `VOCS_OFS_KEY:     reg_rdata <= key_r;
        `VOCS_OFS_MASK:    reg_rdata <= msk_r;
        `VOCS_OFS_GPTR:    reg_rdata <= {24'h00_0000, gptr_r};
        `VOCS_OFS_GPORT:   reg_rdata <= {8'h00, gram_rdata};
        `VOCS_OFS_PLL:     reg_rdata <= pll_r;
        `VOCS_OFS_SIG:     reg_rdata <= {sig_val, sig_ctl_r};
        default:           reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // PLL control decode.  Software must keep the VCO in its legal band.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pll_fb_reset        <= 1'b0;
      pll_half_clock_use  <= 1'b0;
      post_divisor        <= 5'd0;
      pll_feedback_count  <= 11'h000;
      pll_enable          <= 1'b0;
      dot_clock_tv_select <= 1'b0;
      pll_bypass          <= 1'b0;
      input_divisor       <= 4'd0;
      gamma_lookup_data   <= 24'h00_0000;
    end else if (ce) begin
      pll_fb_reset <= pll_r[`VOCS_PLL_FBRST];
      pll_half_clock_use <= ~pll_r[`VOCS_PLL_HALF] &
                            pd_val[0];
      post_divisor <= pd_val;
      pll_feedback_count <=
        pll_r[`VOCS_PLL_N_HI:`VOCS_PLL_N_LO];
      pll_enable <= pll_r[`VOCS_PLL_ON] |
                    (pd_code == `VOCS_PD_ONE);
      dot_clock_tv_select <= pll_r[`VOCS_PLL_TVSEL];
      pll_bypass <= pll_r[`VOCS_PLL_BYP];
      input_divisor <= {1'b0, pll_r[2:0]} + 4'd2;
      gamma_lookup_data <= gram_lkdata;
    end
  end

  always @* begin
    ovl_x_start = hb_r[10:0];
    ovl_x_end   = hb_r[26:16];
    ovl_y_start = vb_r[10:0];
    ovl_y_end   = vb_r[26:16];
    ovl_x_scale = sc_r[13:0];
    ovl_y_scale = sc_r[29:16];
  end

  // Colour keying on registered stream samples.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_gfx_r <= 24'h00_0000;
      key_vid_r <= 24'h00_0000;
      use_vid_r <= 1'b0;
    end else if (ce) begin
      key_gfx_r <= gfx_pixel;
      key_vid_r <= vid_pixel;
      use_vid_r <= key_use_video;
    end
  end

  assign key_src   = use_vid_r ? key_vid_r : key_gfx_r;
  assign key_match = ((key_src ^ key_r[23:0]) & msk_r[23:0])
                     == 24'h00_0000;

  // Panel sync and clock outputs.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hs_dly_r                     <= 2'b00;
      panel_vertical_sync_output   <= 1'b0;
      panel_horizontal_sync_output <= 1'b0;
      panel_clock_output           <= 1'b0;
      panel_even_pixel_clock       <= 1'b0;
    end else if (ce) begin
      hs_dly_r <= {hs_dly_r[0], hs_s_r[1]};
      if (sig_ctl_r[`VOCS_SIG_OVR]) begin
        panel_vertical_sync_output <= vs_s_r[1];
        panel_horizontal_sync_output <= sig_ctl_r[`VOCS_SIG_HDLY] ?
          hs_dly_r[`VOCS_HSYNC_DLY-1] : hs_s_r[1];
      end else begin
        panel_vertical_sync_output   <= pvs_s_r[1];
        panel_horizontal_sync_output <= phs_s_r[1];
      end
      panel_clock_output <= pck_s_r[1] ^
                            sig_ctl_r[`VOCS_SIG_INVCLK];
      panel_even_pixel_clock <= pev_s_r[1] ^
                                sig_ctl_r[`VOCS_SIG_INVEVEN];
    end
  end

  // Signature capture window: armed at the next vsync, ends at frame end unless free run is set.
  assign vs_rise = vs_s_r[1] & ~vs_d_r;
  assign sig_pix = sig_ctl_r[`VOCS_SIG_SRC] ?
    {panel_pixel[17:12], 2'b00, panel_pixel[11:6], 2'b00,
     panel_pixel[5:0], 2'b00} : rgb_pixel;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      vs_d_r     <= 1'b0;
      cap_r      <= 1'b0;
      sig_done_r <= 1'b0;
    end else if (ce) begin
      vs_d_r <= vs_s_r[1];
      if (!sig_ctl_r[`VOCS_SIG_EN]) begin
        cap_r      <= 1'b0;
        sig_done_r <= 1'b0;
      end else if (vs_rise) begin
        // A frame ends at vsync; without free run the result then holds
        // until enable drops, so software reads a settled signature.
        cap_r <= (~cap_r & ~sig_done_r) |
                 (cap_r & sig_ctl_r[`VOCS_SIG_FREE]);
        sig_done_r <= sig_done_r |
                      (cap_r & ~sig_ctl_r[`VOCS_SIG_FREE]);
      end
    end
  end

  vocs_sig_crc u_sig (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .clear   (~sig_ctl_r[`VOCS_SIG_EN]),
    .step    (cap_r),
    .pix     (sig_pix),
    .sig_r   (sig_val)
  );
endmodule // vocs_top

// ==== verif/vocs_chk.sv ====
// Concurrent checks on the overlay, pixel clock and signature register bank.
`timescale 1ns/1ps
`include "vocs_consts.vh"
module vocs_chk (
  input wire        clk,
  input wire        sys_rst,
  input wire        ce,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire [10:0] ovl_x_start,
  input wire [10:0] ovl_x_end,
  input wire [13:0] ovl_x_scale,
  input wire [13:0] ovl_y_scale,
  input wire        pll_fb_reset,
  input wire [4:0]  post_divisor,
  input wire [10:0] pll_feedback_count,
  input wire        pll_enable,
  input wire        dot_clock_tv_select,
  input wire        pll_bypass,
  input wire [3:0]  input_divisor
);
  reg [31:0] wd_r;
  reg [31:0] pll_r;
  // The copy follows only accepted setup writes, so other traffic cannot
  // disturb the comparison while the outputs settle.
  always @(posedge clk) begin
    wd_r <= reg_wdata;
    if (ce && reg_wr && reg_addr == `VOCS_OFS_PLL)
      pll_r <= reg_wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr(logic [7:0] a);
    ce && reg_wr && reg_addr == a;
  endsequence
  sequence s_quiet;
    ce && !(reg_wr && reg_addr == `VOCS_OFS_PLL);
  endsequence
  sequence s_pll_done;
    s_wr(`VOCS_OFS_PLL) ##1 s_quiet ##1 s_quiet;
  endsequence
  a_xbounds_load: assert property (
    s_wr(`VOCS_OFS_HBOUNDS) |=> ovl_x_start == wd_r[10:0]
      && ovl_x_end == wd_r[26:16]) else $error("overlay x bounds wrong");
  a_scale_load: assert property (
    s_wr(`VOCS_OFS_SCALE) |=> ovl_y_scale == wd_r[29:16]
      && ovl_x_scale == wd_r[13:0]) else $error("scale factors wrong");
  a_fb_reset: assert property (
    s_pll_done |-> pll_fb_reset == pll_r[31]) else $error("fb reset wrong");
  a_post_one: assert property (
    s_pll_done |-> pll_r[28:24] != `VOCS_PD_ONE || post_divisor == 5'h01)
    else $error("post divisor one wrong");
  a_fb_count: assert property (
    s_pll_done |-> pll_feedback_count == pll_r[22:12])
    else $error("feedback count wrong");
  a_pll_gate: assert property (
    s_pll_done |-> pll_enable == (pll_r[11] || pll_r[28:24] == `VOCS_PD_ONE))
    else $error("pll enable wrong");
  a_clock_route: assert property (
    s_pll_done |-> dot_clock_tv_select == pll_r[10] && pll_bypass == pll_r[8])
    else $error("clock routing wrong");
  a_input_div: assert property (
    s_pll_done |-> input_divisor == {1'b0, pll_r[2:0]} + 4'h2)
    else $error("input divisor wrong");
  a_key_reserved: assert property (
    ce && reg_rd && reg_addr == `VOCS_OFS_KEY |=> reg_rdata[31:24] == 8'h00)
    else $error("key reserved bits set");
  a_sig_reserved: assert property (
    ce && reg_rd && reg_addr == `VOCS_OFS_SIG |=> !reg_rdata[4])
    else $error("signature bit 4 set");
endmodule // vocs_chk

bind vocs_top vocs_chk chk_u (
  .clk, .sys_rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .ovl_x_start, .ovl_x_end, .ovl_x_scale, .ovl_y_scale, .pll_fb_reset,
  .post_divisor, .pll_feedback_count, .pll_enable, .dot_clock_tv_select,
  .pll_bypass, .input_divisor);

// ==== verif/vocs_top_test.sv ====
// Self-checking bench for the overlay, pixel clock and signature bank.
`timescale 1ns/1ps
`include "vocs_consts.vh"
module vocs_top_test;
  logic        clk, sys_rst, ce, reg_wr, reg_rd, key_use_video;
  logic        crt_vsync, crt_hsync, panel_vsync_in, panel_hsync_in;
  logic        panel_clk_in, panel_even_clk_in, taken;
  logic [7:0]  reg_addr, gamma_lookup_idx;
  logic [31:0] reg_wdata, k, m;
  logic [23:0] gfx_pixel, vid_pixel, rgb_pixel, px;
  logic [17:0] panel_pixel;
  wire  [31:0] reg_rdata;
  wire  [23:0] gamma_lookup_data;
  wire  [10:0] ovl_x_start, ovl_x_end, ovl_y_start, ovl_y_end;
  wire  [10:0] pll_feedback_count;
  wire  [13:0] ovl_x_scale, ovl_y_scale;
  wire  [4:0]  post_divisor;
  wire  [3:0]  input_divisor;
  wire         key_match, panel_vertical_sync_output, panel_clock_output;
  wire         panel_horizontal_sync_output, panel_even_pixel_clock;
  wire         pll_fb_reset, pll_half_clock_use, pll_enable;
  wire         dot_clock_tv_select, pll_bypass;
  int          bad_count, total_checks, k0, k1;
  logic [31:0] exp_q[$], d[5];
  logic [31:0] msk[5] = '{`VOCS_POS_MASK, `VOCS_POS_MASK, `VOCS_SCALE_MASK,
                          `VOCS_C24_MASK, `VOCS_C24_MASK};
  logic [4:0]  pd_tbl[32] = '{5'h08, 5'h06, 5'h12, 5'h04, 5'h0c, 5'h10,
    5'h18, 5'h02, 5'h0a, 5'h14, 5'h0e, 5'h1a, 5'h16, 5'h1c, 5'h1e, 5'h01,
    5'h09, 5'h07, 5'h13, 5'h05, 5'h0d, 5'h11, 5'h19, 5'h03, 5'h0b, 5'h15,
    5'h0f, 5'h1b, 5'h17, 5'h1d, 5'h1f, 5'h00};

  vocs_top dut_u (
    .clk, .sys_rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .gfx_pixel, .vid_pixel, .key_use_video, .key_match, .panel_pixel,
    .rgb_pixel, .crt_vsync, .crt_hsync, .panel_vsync_in, .panel_hsync_in,
    .panel_clk_in, .panel_even_clk_in, .panel_vertical_sync_output,
    .panel_horizontal_sync_output, .panel_clock_output,
    .panel_even_pixel_clock, .ovl_x_start, .ovl_x_end, .ovl_y_start,
    .ovl_y_end, .ovl_x_scale, .ovl_y_scale, .gamma_lookup_idx,
    .gamma_lookup_data, .pll_fb_reset, .pll_half_clock_use, .post_divisor,
    .pll_feedback_count, .pll_enable, .dot_clock_tv_select, .pll_bypass,
    .input_divisor);

  always #50 clk = ~clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, want);
    end
  endtask

  // One bus cycle per call; strobes stay up across back-to-back calls.
  task automatic acc(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] v);
    @(posedge clk);
    #1;
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = v;
  endtask

  task automatic idle();
    acc(1'b0, 1'b0, 8'h00, 32'h0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, a, 32'h0000_0000);
  endtask

  // Cycles from a sync rise on the tube side to the panel hsync output.
  task automatic lag(input logic [31:0] v, output int n);
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, v);
    repeat (4) idle();
    crt_hsync = 1'b1;
    n = 0;
    while (panel_horizontal_sync_output !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20) begin
      bad_count++;
      conclude();
    end
    crt_hsync = 1'b0;
    repeat (8) idle();
  endtask

  // A vsync pulse of n clocks, high for the first half.
  task automatic vpulse(input int n);
    crt_vsync = 1'b1;
    repeat (n / 2) idle();
    crt_vsync = 1'b0;
    repeat (n / 2) idle();
  endtask

  // Signature after n steps over one constant pixel, from the seed.
  function automatic logic [23:0] crc_ref(input logic [23:0] p,
                                          input int n);
    logic [23:0] s;
    s = `VOCS_SIG_SEED;
    repeat (n)
      for (int b = 0; b < 24; b++)
        s = {s[22:0], 1'b0} ^ ((s[23] ^ p[b]) ? `VOCS_CRC_POLY : 24'h0);
    return s;
  endfunction

  // Reads answer at the edge that takes them; compare at the falling edge.
  always @(posedge clk) taken <= reg_rd && ce && !sys_rst;
  always @(negedge clk) begin
    if (taken) begin
      if (exp_q.size() == 0)
        check(32'h0000_0000, 32'h0000_0001);
      else
        check(reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    #5_000_000;
    bad_count++;
    conclude();
  end

  initial begin
    {reg_wr, reg_rd, key_use_video, crt_vsync, crt_hsync, panel_vsync_in,
     panel_hsync_in, panel_clk_in, panel_even_clk_in, reg_addr, reg_wdata,
     gamma_lookup_idx, gfx_pixel, vid_pixel, rgb_pixel, panel_pixel} = '0;
    clk = 1'b0;
    sys_rst = 1'b1;
    ce = 1'b1;
    void'($urandom(32'h4f7e));
    rgb_pixel = $urandom;
    panel_pixel = 18'($urandom);
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rd(`VOCS_OFS_PLL, `VOCS_PLL_RST);
    rd(`VOCS_OFS_SIG, `VOCS_SIG_RST);
    rd(8'h2c, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      d[i] = $urandom;
      acc(1'b1, 1'b0, 8'h08 + 8'(4 * i), d[i]);
    end
    acc(1'b1, 1'b0, 8'h2c, 32'hffff_ffff);
    for (int i = 0; i < 5; i++)
      rd(8'h08 + 8'(4 * i), d[i] & msk[i]);
    rd(8'h2c, 32'h0000_0000);
    idle();
    // With the clock enable low the write below must be lost.
    ce = 1'b0;
    acc(1'b1, 1'b0, `VOCS_OFS_HBOUNDS, ~d[0]);
    idle();
    ce = 1'b1;
    rd(`VOCS_OFS_HBOUNDS, d[0] & msk[0]);
    idle();
    $display("register readback test done");
    m = $urandom & `VOCS_C24_MASK;
    k = $urandom & m;
    acc(1'b1, 1'b0, `VOCS_OFS_KEY, k);
    acc(1'b1, 1'b0, `VOCS_OFS_MASK, m | 32'hff00_0000);
    idle();
    for (int i = 0; i < 16; i++) begin
      px = i[0] ? k[23:0] | (24'($urandom) & ~m[23:0]) : 24'($urandom);
      key_use_video = i[1];
      gfx_pixel = i[1] ? 24'($urandom) : px;
      vid_pixel = i[1] ? px : 24'($urandom);
      @(posedge clk);
      #1;
      check(key_match, (px & m[23:0]) == k[23:0]);
    end
    $display("colour key test done");
    d[0] = $urandom;
    d[1] = $urandom;
    acc(1'b1, 1'b0, `VOCS_OFS_GPTR, 32'h0000_0005);
    acc(1'b1, 1'b0, `VOCS_OFS_GPORT, d[0]);
    acc(1'b1, 1'b0, `VOCS_OFS_GPORT, d[1]);
    acc(1'b1, 1'b0, `VOCS_OFS_GPTR, 32'h0000_0005);
    rd(`VOCS_OFS_GPORT, d[0] & `VOCS_C24_MASK);
    rd(`VOCS_OFS_GPORT, d[1] & `VOCS_C24_MASK);
    idle();
    gamma_lookup_idx = 8'h06;
    @(posedge clk);
    #1;
    check(gamma_lookup_data, d[1] & `VOCS_C24_MASK);
    $display("gamma test done");
    for (int c = 0; c < 32; c++) begin
      d[0] = ($urandom & `VOCS_PLL_MASK & 32'he0ff_ffff) | (32'(c) << 24);
      acc(1'b1, 1'b0, `VOCS_OFS_PLL, d[0]);
      rd(`VOCS_OFS_PLL, d[0]);
      repeat (2) idle();
      check({pll_fb_reset, pll_half_clock_use, post_divisor,
             pll_feedback_count, pll_enable, dot_clock_tv_select,
             pll_bypass, input_divisor},
            {d[0][31], ~d[0][30] & pd_tbl[c][0], pd_tbl[c], d[0][22:12],
             c == 15 || d[0][11], d[0][10], d[0][8],
             4'(d[0][2:0]) + 4'h2});
    end
    $display("pixel clock setup test done");
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_00fe);
    rd(`VOCS_OFS_SIG, 32'h0000_01ee);
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_00c0);
    crt_vsync = 1'b1;
    crt_hsync = 1'b1;
    repeat (6) idle();
    check({panel_vertical_sync_output, panel_horizontal_sync_output,
           panel_clock_output, panel_even_pixel_clock}, 4'b1110);
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_0020);
    repeat (6) idle();
    check({panel_vertical_sync_output, panel_horizontal_sync_output,
           panel_clock_output, panel_even_pixel_clock}, 4'b0001);
    crt_vsync = 1'b0;
    crt_hsync = 1'b0;
    lag(32'h0000_0080, k0);
    lag(32'h0000_0082, k1);
    check(k1 - k0, 32'h0000_0002);
    $display("panel sync test done");
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_0001);
    repeat (8) idle();
    rd(`VOCS_OFS_SIG, 32'h0000_0101);
    vpulse(16);
    vpulse(16);
    rd(`VOCS_OFS_SIG, {crc_ref(rgb_pixel, 16), 8'h01});
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_0000);
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_000d);
    vpulse(16);
    vpulse(8);
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_0009);
    vpulse(8);
    vpulse(8);
    px = {panel_pixel[17:12], 2'b00, panel_pixel[11:6], 2'b00,
          panel_pixel[5:0], 2'b00};
    rd(`VOCS_OFS_SIG, {crc_ref(px, 25), 8'h09});
    acc(1'b1, 1'b0, `VOCS_OFS_SIG, 32'h0000_0000);
    idle();
    rd(`VOCS_OFS_SIG, `VOCS_SIG_RST);
    repeat (3) idle();
    $display("signature test done");
    conclude();
  end
endmodule // vocs_top_test
